/* logic/sdms_defines.svh */
// Offsets, field positions, reset values and counts of the step/dir sequencer
`ifndef SDMS_DEFINES_SVH
`define SDMS_DEFINES_SVH

`define SDMS_ADDR_CTRL       4'h0
`define SDMS_ADDR_STATUS     4'h4
`define SDMS_ADDR_CUR_UV     4'h8
`define SDMS_ADDR_CUR_W      4'hc

`define SDMS_CTRL_MRES_LSB   0
`define SDMS_CTRL_MRES_MSB   3
`define SDMS_CTRL_DUAL_BIT   4
`define SDMS_CTRL_INTERP_BIT 5
`define SDMS_CTRL_SDMODE_BIT 6
`define SDMS_CTRL_RESET      32'h0000_0044

`define SDMS_STAT_POS_LSB    16
`define SDMS_CUR_V_LSB       16

`define SDMS_MRES_MAX        4'h8
`define SDMS_MRES_INTERP     4'h4
`define SDMS_FINE_STEPS      5'h10
`define SDMS_PHASE_V_OFS     10'h155
`define SDMS_PEAK            9'h0f8

`define SDMS_MAX_FINE_PERIOD 1048576
`define SDMS_SLOW_PERIOD     65536

`endif

/* logic/sdms_pkg.sv */
// Shared types of the step/dir sequencer
package sdms_pkg;
    typedef logic signed [8:0] sdms_cur_t;
    typedef logic [9:0]        sdms_pos_t;
endpackage

/* logic/sdms_sine_if.sv */
// Index and value lines between the sequencer and its sine table
`timescale 1ns/1ps
interface sdms_sine_if;
    sdms_pkg::sdms_pos_t idx_u;
    sdms_pkg::sdms_pos_t idx_v;
    sdms_pkg::sdms_cur_t val_u;
    sdms_pkg::sdms_cur_t val_v;
    modport req (output idx_u, output idx_v, input val_u, input val_v);
    modport tab (input idx_u, input idx_v, output val_u, output val_v);
endinterface

/* logic/sdms_sine_lut.sv */
// Quarter-wave sine table unfolded to a full 1024-entry period
`timescale 1ns/1ps
module sdms_sine_lut (
    sdms_sine_if.tab tab
);
    // Entry 0 sits in the top byte
    localparam logic [2047:0] QTAB = {
        128'h0102_0405_0708_0a0b_0d0e_1011_1315_1618,
        128'h191b_1c1e_1f21_2224_2527_282a_2b2d_2e30,
        128'h3133_3436_3739_3a3c_3d3e_4041_4344_4647,
        128'h494a_4c4d_4f50_5153_5456_5759_5a5b_5d5e,
        128'h6061_6264_6567_6869_6b6c_6d6f_7072_7374,
        128'h7677_787a_7b7c_7e7f_8081_8384_8587_8889,
        128'h8a8c_8d8e_8f91_9293_9496_9798_999a_9c9d,
        128'h9e9f_a0a1_a3a4_a5a6_a7a8_a9aa_acad_aeaf,
        128'hb0b1_b2b3_b4b5_b6b7_b8b9_babb_bcbd_bebf,
        128'hc0c1_c2c3_c4c5_c6c7_c8c9_c9ca_cbcc_cdce,
        128'hcfcf_d0d1_d2d3_d4d4_d5d6_d7d7_d8d9_dada,
        128'hdbdc_dcdd_dedf_dfe0_e1e1_e2e2_e3e4_e4e5,
        128'he5e6_e7e7_e8e8_e9e9_eaea_ebeb_ecec_eded,
        128'heeee_eeef_eff0_f0f0_f1f1_f1f2_f2f2_f3f3,
        128'hf3f4_f4f4_f4f5_f5f5_f5f6_f6f6_f6f6_f7f7,
        128'hf7f7_f7f7_f7f7_f8f8_f8f8_f8f8_f8f8_f8f8
    };

    // Bit 8 mirrors the index, bit 9 negates the value
    function automatic sdms_pkg::sdms_cur_t sine_at(
        input sdms_pkg::sdms_pos_t idx
    );
        logic [7:0] f;
        logic [7:0] mag;
        f   = idx[8] ? ~idx[7:0] : idx[7:0];
        mag = QTAB[{~f, 3'b000} +: 8];
        return idx[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction

    assign tab.val_u = sine_at(tab.idx_u);
    assign tab.val_v = sine_at(tab.idx_v);
endmodule // sdms_sine_lut

/* logic/sdms_sequencer.sv */
// Step/dir microstep sequencer with step rate multiplier
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "sdms_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Step and dir registered on clk first
// - Waveform from 1024-entry sine period
// - Sine amplitude peaks at plus/minus 248
// - Dir low adds width, high subtracts
// - Quarter table, mirror and negate rest
// - Stored quarter exactly as tabulated
// - Phase V shifted 120 degrees
// - Phase W is minus U plus V
// - Step width doubles per resolution halving
// - Resolution change applies next step, keeps count
// - Multiplier needs enable, 16 steps, step mode
// - Each input step gives 16 fine steps
// - Fine period is step interval over 16
// - Fine period bounded to 2^20 cycles
// - Stand-still flag set on interval expiry
// - Slow case steps at clk over 2^16
module sdms_sequencer #(
    parameter int MAX_FINE_PERIOD = `SDMS_MAX_FINE_PERIOD,
    parameter int SLOW_PERIOD     = `SDMS_SLOW_PERIOD
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                step_in,
    input  wire logic                dir_in,
    input  wire logic [3:0]          addr,
    input  wire logic [31:0]         wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [31:0]         rd_data,
    output sdms_pkg::sdms_cur_t      phase_u_current,
    output sdms_pkg::sdms_cur_t      phase_v_current,
    output sdms_pkg::sdms_cur_t      phase_w_current,
    output sdms_pkg::sdms_pos_t      position,
    output logic                     stand_still
);
    localparam logic [24:0] EXPIRE = 25'(16 * MAX_FINE_PERIOD);
    localparam logic [20:0] SLOW_P = 21'(SLOW_PERIOD);
    localparam logic [20:0] MAX_P  = 21'(MAX_FINE_PERIOD);
    localparam logic [31:0] CTRL_RST = `SDMS_CTRL_RESET;
    localparam int          MR_HI    = `SDMS_CTRL_MRES_MSB;
    localparam int          MR_LO    = `SDMS_CTRL_MRES_LSB;

    logic                step_s_ff;
    logic                dir_s_ff;
    logic                step_prev_ff;
    logic [3:0]          mres_ff;
    logic                dual_edge_step_en_ff;
    logic                step_interpolation_en_ff;
    logic                step_dir_mode_ff;
    sdms_pkg::sdms_pos_t pos_ff;
    logic [24:0]         interval_ff;
    logic [20:0]         period_ff;
    logic [20:0]         fine_tmr_ff;
    logic [4:0]          pending_ff;
    logic                fine_dir_ff;
    logic                stand_still_ff;
    sdms_pkg::sdms_cur_t cur_u_ff;
    sdms_pkg::sdms_cur_t cur_v_ff;
    sdms_pkg::sdms_cur_t cur_w_ff;
    logic [31:0]         rd_data_ff;

    logic                step_evt;
    logic                interp_act;
    logic                fine_tick;
    logic [9:0]          width;
    logic [20:0]         meas_period;
    logic [20:0]         nxt_period;
    logic signed [9:0]   uv_sum;

    sdms_sine_if sine_bus ();

    sdms_sine_lut u_lut (
        .tab (sine_bus.tab)
    );

    ////////////////////////////////////////////////////////////////////////
    // Input sampling and edge detection

    always_ff @(posedge clk) begin
        if (rst) begin
            step_s_ff    <= 1'b0;
            dir_s_ff     <= 1'b0;
            step_prev_ff <= 1'b0;
        end else begin
            step_s_ff    <= step_in;
            dir_s_ff     <= dir_in;
            step_prev_ff <= step_s_ff;
        end
    end

    // Step inputs only count in step/dir mode
    assign step_evt = step_dir_mode_ff
                      && (step_s_ff != step_prev_ff)
                      && (dual_edge_step_en_ff || step_s_ff);

    assign interp_act = step_interpolation_en_ff && step_dir_mode_ff
                        && (mres_ff == `SDMS_MRES_INTERP);

    // Resolution codes above the maximum are clamped to full step
    assign width = 10'h001 << ((mres_ff > `SDMS_MRES_MAX) ?
                               `SDMS_MRES_MAX : mres_ff);

    assign fine_tick = interp_act && (pending_ff != 5'h00)
                       && ((fine_tmr_ff + 21'h00_0001) >= period_ff);

    // A zero period would tick every cycle just as one does; the period floors at one
    assign meas_period = interval_ff[24:4];

    always_comb begin
        if (stand_still_ff) begin
            nxt_period = SLOW_P;
        end else if (meas_period > MAX_P) begin
            nxt_period = MAX_P;
        end else if (meas_period == 21'h00_0000) begin
            nxt_period = 21'h00_0001;
        end else begin
            nxt_period = meas_period;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge clk) begin
        if (rst) begin
            mres_ff                  <= CTRL_RST[MR_HI:MR_LO];
            dual_edge_step_en_ff     <= CTRL_RST[`SDMS_CTRL_DUAL_BIT];
            step_interpolation_en_ff <= CTRL_RST[`SDMS_CTRL_INTERP_BIT];
            step_dir_mode_ff         <= CTRL_RST[`SDMS_CTRL_SDMODE_BIT];
        end else if (wr_en && addr == `SDMS_ADDR_CTRL) begin
            // Counter is left alone; the new width acts from the next step
            mres_ff                  <= wr_data[MR_HI:MR_LO];
            dual_edge_step_en_ff     <= wr_data[`SDMS_CTRL_DUAL_BIT];
            step_interpolation_en_ff <= wr_data[`SDMS_CTRL_INTERP_BIT];
            step_dir_mode_ff         <= wr_data[`SDMS_CTRL_SDMODE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Microstep counter

    always_ff @(posedge clk) begin
        if (rst) begin
            pos_ff <= 10'h000;
        end else if (step_evt) begin
            if (interp_act) begin
                // Fine steps still owed are flushed so no position is lost
                pos_ff <= fine_dir_ff ? pos_ff - 10'(pending_ff)
                                      : pos_ff + 10'(pending_ff);
            end else begin
                pos_ff <= dir_s_ff ? pos_ff - width
                                   : pos_ff + width;
            end
        end else if (fine_tick) begin
            pos_ff <= fine_dir_ff ? pos_ff - 10'h001
                                  : pos_ff + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interval measurement and stand-still

    always_ff @(posedge clk) begin
        if (rst) begin
            interval_ff    <= 25'h000_0000;
            stand_still_ff <= 1'b0;
        end else if (step_evt) begin
            interval_ff    <= 25'h000_0000;
            stand_still_ff <= 1'b0;
        end else if (interval_ff != EXPIRE) begin
            interval_ff <= interval_ff + 25'h000_0001;
            if (interval_ff == EXPIRE - 25'h000_0001) begin
                stand_still_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step rate multiplier

    always_ff @(posedge clk) begin
        if (rst) begin
            period_ff   <= SLOW_P;
            fine_tmr_ff <= 21'h00_0000;
            pending_ff  <= 5'h00;
            fine_dir_ff <= 1'b0;
        end else if (!interp_act) begin
            pending_ff  <= 5'h00;
            fine_tmr_ff <= 21'h00_0000;
        end else if (step_evt) begin
            period_ff   <= nxt_period;
            fine_tmr_ff <= 21'h00_0000;
            pending_ff  <= `SDMS_FINE_STEPS;
            fine_dir_ff <= dir_s_ff;
        end else begin
            if (interval_ff == EXPIRE - 25'h000_0001) begin
                period_ff <= SLOW_P;
            end
            if (fine_tick) begin
                fine_tmr_ff <= 21'h00_0000;
                pending_ff  <= pending_ff - 5'h01;
            end else if (pending_ff != 5'h00) begin
                fine_tmr_ff <= fine_tmr_ff + 21'h00_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Coil current targets

    assign sine_bus.idx_u = pos_ff;
    assign sine_bus.idx_v = pos_ff - `SDMS_PHASE_V_OFS;
    assign uv_sum = 10'(sine_bus.val_u) + 10'(sine_bus.val_v);

    always_ff @(posedge clk) begin
        if (rst) begin
            cur_u_ff <= 9'h000;
            cur_v_ff <= 9'h000;
            cur_w_ff <= 9'h000;
        end else begin
            cur_u_ff <= sine_bus.val_u;
            cur_v_ff <= sine_bus.val_v;
            // U and V stay 120 degrees apart, so the sum fits nine bits
            cur_w_ff <= 9'(-uv_sum);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port

    function automatic logic [31:0] reg_read(input logic [3:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `SDMS_ADDR_CTRL: begin
                d[`SDMS_CTRL_MRES_MSB:`SDMS_CTRL_MRES_LSB] = mres_ff;
                d[`SDMS_CTRL_DUAL_BIT]   = dual_edge_step_en_ff;
                d[`SDMS_CTRL_INTERP_BIT] = step_interpolation_en_ff;
                d[`SDMS_CTRL_SDMODE_BIT] = step_dir_mode_ff;
            end
            `SDMS_ADDR_STATUS: begin
                d[0] = stand_still_ff;
                d[`SDMS_STAT_POS_LSB +: 10] = pos_ff;
            end
            `SDMS_ADDR_CUR_UV: begin
                d[8:0] = cur_u_ff;
                d[`SDMS_CUR_V_LSB +: 9] = cur_v_ff;
            end
            `SDMS_ADDR_CUR_W: begin
                d[8:0] = cur_w_ff;
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            rd_data_ff <= reg_read(addr);
        end else begin
            rd_data_ff <= 32'h0000_0000;
        end
    end

    assign rd_data         = rd_data_ff;
    assign phase_u_current = cur_u_ff;
    assign phase_v_current = cur_v_ff;
    assign phase_w_current = cur_w_ff;
    assign position        = pos_ff;
    assign stand_still     = stand_still_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_step_rise_sampled: assert property (
        step_evt && !dual_edge_step_en_ff && !$past(rst, 2)
        |-> $past(step_in) && !$past(step_in, 2))
        else $error("step event without a sampled rising edge");

    a_step_evt_single: assert property (
        step_evt && !dual_edge_step_en_ff |=> !step_evt)
        else $error("single-edge step event longer than one cycle");

    a_pos_add_dir: assert property (
        step_evt && !interp_act && !dir_s_ff
        |=> pos_ff == 10'($past(pos_ff) + $past(width)))
        else $error("low dir step did not add width");

    a_pos_sub_dir: assert property (
        step_evt && !interp_act && dir_s_ff && mres_ff == 4'h3
        |=> pos_ff == 10'($past(pos_ff) - 10'h008))
        else $error("high dir step at code 3 did not subtract 8");

    a_res_keeps_pos: assert property (
        wr_en && addr == `SDMS_ADDR_CTRL && !step_evt && !fine_tick
        |=> pos_ff == $past(pos_ff))
        else $error("resolution write moved the counter");

    a_no_fine_off: assert property (
        !interp_act |-> !fine_tick)
        else $error("fine step while multiplier inactive");

    a_fine_load: assert property (
        interp_act && step_evt |=> pending_ff == `SDMS_FINE_STEPS)
        else $error("input step did not queue 16 fine steps");

    a_fine_period: assert property (
        interp_act |-> period_ff <= MAX_P && period_ff != 21'h00_0000)
        else $error("fine period outside its bound");

    a_still_expiry: assert property (
        interval_ff == EXPIRE - 25'h000_0001 && !step_evt
        |=> stand_still_ff && (period_ff == SLOW_P || !$past(interp_act)))
        else $error("stand-still not set on interval expiry");

    a_w_negsum: assert property (
        10'(phase_w_current) == 10'(-(10'(phase_u_current)
                                    + 10'(phase_v_current))))
        else $error("phase W is not minus U plus V");

    a_sine_peak: assert property (
        $signed(phase_u_current) <= $signed(`SDMS_PEAK)
        && $signed(phase_u_current) >= -$signed(`SDMS_PEAK))
        else $error("phase U beyond 248");

    c_dual_edge_fall: cover property (
        step_evt && dual_edge_step_en_ff && !step_s_ff);
    c_fine_burst_done: cover property (
        interp_act && pending_ff == 5'h01 && fine_tick);
    c_still_rise: cover property ($rose(stand_still_ff));
    c_reverse_step: cover property (step_evt && dir_s_ff && !interp_act);
endmodule // sdms_sequencer

/* testbench/sdms_step_src.sv */
// Motion controller model driving the step and direction levels
`timescale 1ns/1ps
module sdms_step_src (
    input  wire logic clk,
    output logic      step_out,
    output logic      dir_out
);
    initial begin
        step_out = 1'b0;
        dir_out  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Called right after a rising edge; the period is hi plus lo cycles.
    // High and low each last at least one cycle, so the rate stays legal.
    task automatic pulse(input logic d, input int hi, input int lo);
        dir_out  <= d;
        step_out <= 1'b1;
        repeat (hi) @(posedge clk);
        step_out <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask

    // Even spacing keeps a 50% duty cycle for dual edge stepping
    task automatic toggle(input logic d, input int gap);
        dir_out  <= d;
        step_out <= ~step_out;
        repeat (gap) @(posedge clk);
    endtask
endmodule // sdms_step_src

/* testbench/step_dir_microstep_sequencer_tb_top.sv */
// Self-checking bench of the step/dir microstep sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("[ERR] %s exp=%h got=%h", nm, exp, got); \
        end \
    end

module step_dir_microstep_sequencer_tb_top;
    logic                clk;
    logic                rst;
    logic                step_in;
    logic                dir_in;
    logic [3:0]          addr;
    logic [31:0]         wr_data;
    logic                wr_en;
    logic                rd_en;
    logic [31:0]         rd_data;
    sdms_pkg::sdms_cur_t phase_u_current;
    sdms_pkg::sdms_cur_t phase_v_current;
    sdms_pkg::sdms_cur_t phase_w_current;
    sdms_pkg::sdms_pos_t position;
    logic                stand_still;
    sdms_pkg::sdms_pos_t pos_q;
    sdms_pkg::sdms_pos_t exp_pos;
    logic [31:0]         rdv;
    int                  error_cnt;
    int                  n_checks;
    int                  cyc;
    int                  t_last;
    int                  gap_last;

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Short counts keep stand-still expiry at 256 cycles
    sdms_sequencer #(.MAX_FINE_PERIOD(16), .SLOW_PERIOD(8)) i_dut (
        .clk(clk), .rst(rst), .step_in(step_in), .dir_in(dir_in),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .phase_u_current(phase_u_current),
        .phase_v_current(phase_v_current),
        .phase_w_current(phase_w_current),
        .position(position), .stand_still(stand_still)
    );

    sdms_step_src i_src (
        .clk(clk), .step_out(step_in), .dir_out(dir_in)
    );

    // Spacing of the latest two position changes
    always @(posedge clk) begin
        cyc++;
        if (position !== pos_q) begin
            gap_last = cyc - t_last;
            t_last   = cyc;
        end
        pos_q = position;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Lowering the strobe costs one idle edge so no signal is set twice
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        d = rd_data;
    endtask

    task automatic mv(input int code, input logic d, input logic [9:0] ep);
        wr(4'h0, 32'h0000_0040 | 32'(code));
        i_src.pulse(d, 3, 3);
        `CHK("position", ep, position)
    endtask

    task automatic wait_still(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if (stand_still === 1'b1) break;
            @(posedge clk);
        end
        if (i == lim) begin
            error_cnt++;
            $display("[ERR] stand_still exp=1 got=%b", stand_still);
            finish_test();
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        cyc = 0;
        t_last = 0;
        gap_last = 0;
        pos_q = 10'h000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("pos_rst", 10'h000, position)
        `CHK("still_rst", 1'b0, stand_still)
        `CHK("u_rst", 9'h001, phase_u_current)
        `CHK("v_rst", 9'h129, phase_v_current)
        `CHK("w_rst", 9'h0d6, phase_w_current)
        rd(4'h0, rdv);
        `CHK("ctrl_rst", 32'h0000_0044, rdv)
        wr(4'h4, 32'h0000_00ff);
        rd(4'h0, rdv);
        `CHK("ctrl_ro", 32'h0000_0044, rdv)
        rd(4'h2, rdv);
        `CHK("unmapped", 32'h0000_0000, rdv)
        mv(0, 1'b0, 10'h001);
        `CHK("u_1", 9'h002, phase_u_current)
        `CHK("v_1", 9'h128, phase_v_current)
        `CHK("w_1", 9'h0d6, phase_w_current)
        rd(4'h8, rdv);
        `CHK("cur_uv", 32'h0128_0002, rdv)
        rd(4'hc, rdv);
        `CHK("cur_w", 32'h0000_00d6, rdv)
        rd(4'h4, rdv);
        `CHK("status", 32'h0001_0000, rdv)
        // Coarser codes start on a multiple of their width
        exp_pos = 10'h001;
        for (int k = 0; k <= 8; k++) begin
            exp_pos = exp_pos + (10'h001 << k);
            mv(k, 1'b0, exp_pos);
        end
        `CHK("u_512", 9'h1ff, phase_u_current)
        `CHK("v_512", 9'h0d7, phase_v_current)
        `CHK("w_512", 9'h12a, phase_w_current)
        for (int k = 8; k >= 0; k--) begin
            exp_pos = exp_pos - (10'h001 << k);
            mv(k, 1'b1, exp_pos);
        end
        mv(0, 1'b1, 10'h000);
        mv(8, 1'b0, 10'h100);
        `CHK("u_peak", 9'h0f8, phase_u_current)
        `CHK("v_256", 9'h185, phase_v_current)
        `CHK("w_256", 9'h183, phase_w_current)
        mv(9, 1'b0, 10'h200);
        mv(9, 1'b1, 10'h100);
        mv(8, 1'b1, 10'h000);
        // Dual edge at half the fastest legal toggle rate, one edge every two cycles
        wr(4'h0, 32'h0000_0050);
        for (int k = 0; k < 8; k++) begin
            i_src.toggle(1'b0, 2);
        end
        repeat (4) @(posedge clk);
        `CHK("dual", 10'h008, position)
        wr(4'h0, 32'h0000_0000);
        i_src.pulse(1'b0, 3, 3);
        `CHK("mode_off", 10'h008, position)
        // Interpolation bit alone must not multiply at code 0
        wr(4'h0, 32'h0000_0060);
        i_src.pulse(1'b0, 3, 40);
        `CHK("interp_c0", 10'h009, position)
        wr(4'h0, 32'h0000_0064);
        wait_still(400);
        i_src.pulse(1'b0, 100, 100);
        i_src.pulse(1'b0, 100, 100);
        i_src.pulse(1'b0, 100, 100);
        `CHK("fine_48", 10'h039, position)
        `CHK("fine_gap", 12, gap_last)
        `CHK("still_no", 1'b0, stand_still)
        wait_still(70);
        i_src.pulse(1'b0, 50, 50);
        repeat (60) @(posedge clk);
        `CHK("slow_16", 10'h049, position)
        `CHK("slow_gap", 8, gap_last)
        `CHK("still_clr", 1'b0, stand_still)
        // Reverse burst: 159-cycle interval gives a 9-cycle fine period
        i_src.pulse(1'b1, 50, 50);
        repeat (60) @(posedge clk);
        `CHK("rev_16", 10'h039, position)
        `CHK("rev_gap", 9, gap_last)
        finish_test();
    end
endmodule // step_dir_microstep_sequencer_tb_top
